// ---- design/wps_ctrl.sv ----
// Wireless power-save controller: station modes, group-owner sleep and absence
`timescale 1ns/1ps

module wps_ctrl #(
    parameter int IDLE_COUNT = wps_pkg::IDLE_CYCLES
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Avalon-MM slave
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // MAC side events (same clock)
    input wire logic tx_frame_i,
    input wire logic rx_frame_i,
    input wire logic ack_rx_i,
    input wire logic beacon_i,
    input wire logic dtim_i,
    input wire logic tim_aid_set_i,
    input wire logic more_data_i,
    input wire logic poll_reply_i,
    input wire logic all_clients_asleep_i,
    input wire logic probe_resp_i,
    // MAC requests
    output logic send_pm_frame_o,
    output logic send_ps_poll_o,
    output logic noa_ie_en_o,
    output logic client_tx_allowed_o,
    output logic radio_awake_o,
    output logic absent_o,
    output logic [1:0] station_mode_o
);
    import wps_pkg::*;

    // ==========================================================
    // Registers
    logic [31:0] ctrl_q;
    logic [15:0] ctwin_ms_q;
    logic [15:0] ctwin_live_q;
    logic opp_sleep_en_q;
    logic [7:0] noa_cnt_q;
    logic [31:0] noa_start_q;
    logic [31:0] noa_dur_q;
    logic rd_pend_q;
    logic [31:0] rdata_q;
    wps_state_t state_q;

    logic [1:0] mode;
    logic go_mode;
    logic wr;
    logic [31:0] wmask;
    logic frame_seen;

    assign mode = ctrl_q[CTRL_MODE_LSB +: 2];
    assign go_mode = ctrl_q[CTRL_GO_BIT];
    assign wr = avs_write_i;
    assign frame_seen = tx_frame_i || rx_frame_i;

    always_comb begin
        wmask = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{avs_byteenable_i[b]}};
        end
    end

    // Writes complete at once; reads take one extra cycle
    assign avs_waitrequest_o = avs_read_i && !rd_pend_q;
    assign avs_readdata_o = rdata_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rd_pend_q <= 1'b0;
        end else begin
            rd_pend_q <= avs_read_i && !rd_pend_q;
        end
    end

    // ==========================================================
    // Register writes
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl_q <= RESET_CTRL;
            ctwin_ms_q <= RESET_CTWIN;
            noa_cnt_q <= RESET_NOA_CNT;
            noa_start_q <= RESET_NOA_TIME;
            noa_dur_q <= RESET_NOA_TIME;
        end else if (wr) begin
            unique case (avs_address_i)
                REG_CTRL: ctrl_q <= (ctrl_q & ~wmask) | (avs_writedata_i & wmask);
                REG_CTWIN: ctwin_ms_q <= (ctwin_ms_q & ~wmask[15:0])
                                       | (avs_writedata_i[15:0] & wmask[15:0]);
                REG_NOA_CNT: noa_cnt_q <= avs_byteenable_i[0] ? avs_writedata_i[7:0]
                                                               : noa_cnt_q;
                REG_NOA_START: noa_start_q <= (noa_start_q & ~wmask)
                                            | (avs_writedata_i & wmask);
                REG_NOA_DUR: noa_dur_q <= (noa_dur_q & ~wmask) | (avs_writedata_i & wmask);
                default: ;
            endcase
        end
    end

    // Window length only goes live when the enable is rewritten
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            opp_sleep_en_q <= 1'b0;
            ctwin_live_q <= RESET_CTWIN;
        end else if (wr && avs_address_i == REG_OPP_SLEEP && avs_byteenable_i[0]) begin
            opp_sleep_en_q <= avs_writedata_i[0];
            ctwin_live_q <= ctwin_ms_q;
        end
    end

    // ==========================================================
    // Timers
    logic idle_load, idle_busy, idle_exp;
    logic win_load, win_busy, win_exp;
    logic noa_load, noa_busy, noa_exp;
    logic [31:0] win_count;
    logic [31:0] noa_count;

    wps_ms_timer u_idle (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .load_i(idle_load),
        .count_i(32'(IDLE_COUNT)),
        .busy_o(idle_busy),
        .expire_o(idle_exp)
    );

    wps_ms_timer u_win (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .load_i(win_load),
        .count_i(win_count),
        .busy_o(win_busy),
        .expire_o(win_exp)
    );

    wps_ms_timer u_noa (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .load_i(noa_load),
        .count_i(noa_count),
        .busy_o(noa_busy),
        .expire_o(noa_exp)
    );

    // Idle timer restarts on every frame seen in ST_ADAPT_AWAKE or ST_DOZE
    assign idle_load = frame_seen && (state_q == ST_ADAPT_AWAKE || state_q == ST_DOZE);

    assign win_count = 32'(ctwin_live_q) * 32'(MS_CYCLES);
    assign win_load = beacon_i && go_mode && opp_sleep_en_q;

    // ==========================================================
    // Absence schedule (times in microseconds)
    logic [7:0] noa_left_q;
    logic noa_phase_q; // 0: waiting for start, 1: absent
    logic noa_run_q;

    assign noa_count = ((noa_run_q && !noa_phase_q) ? noa_dur_q : noa_start_q) * 32'(US_CYCLES);
    assign noa_load = (beacon_i && go_mode && ctrl_q[CTRL_NOA_ARM_BIT]
                       && !noa_run_q && noa_cnt_q != 8'h00)
                      || (noa_run_q && noa_exp && !(noa_phase_q && noa_left_q == 8'h01));

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            noa_left_q <= 8'h00;
            noa_phase_q <= 1'b0;
            noa_run_q <= 1'b0;
        end else if (!noa_run_q) begin
            if (noa_load) begin
                noa_run_q <= 1'b1;
                noa_phase_q <= 1'b0;
                noa_left_q <= noa_cnt_q;
            end
        end else if (noa_exp) begin
            if (noa_phase_q) begin
                noa_left_q <= noa_left_q - 8'h01;
                noa_run_q <= (noa_left_q != 8'h01);
            end
            noa_phase_q <= !noa_phase_q;
        end
    end

    // Element advertised while a schedule is armed
    assign noa_ie_en_o = go_mode && ctrl_q[CTRL_NOA_ARM_BIT]
                         && (beacon_i || probe_resp_i);
    assign absent_o = noa_run_q && noa_phase_q && noa_busy;

    // ==========================================================
    // Power-save state machine
    logic [15:0] polls_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= ST_AWAKE;
        end else if (go_mode) begin
            unique case (state_q)
                ST_GO_WINDOW: if (win_exp && !win_load) begin
                    state_q <= all_clients_asleep_i ? ST_GO_SLEEP : ST_GO_HOLD;
                end
                ST_GO_HOLD, ST_GO_SLEEP: if (win_load) begin
                    state_q <= ST_GO_WINDOW;
                end
                // A beacon that lands on entry opens the window at once
                default: state_q <= !opp_sleep_en_q ? ST_AWAKE
                                  : (win_load ? ST_GO_WINDOW : ST_GO_HOLD);
            endcase
        end else begin
            unique case (state_q)
                ST_AWAKE: begin
                    // Adaptive entry dozes at once; traffic wakes it later
                    if (mode == MODE_LEGACY || mode == MODE_ADAPTIVE) begin
                        state_q <= ST_ANNOUNCE;
                    end
                end
                ST_ANNOUNCE: state_q <= ST_WAIT_ACK;
                ST_WAIT_ACK: begin
                    if (mode == MODE_NO_PS) begin
                        state_q <= ST_AWAKE;
                    end else if (ack_rx_i) begin
                        state_q <= ST_DOZE;
                    end
                end
                ST_DOZE: begin
                    if (mode == MODE_NO_PS) begin
                        state_q <= ST_AWAKE;
                    end else if (mode == MODE_ADAPTIVE && frame_seen) begin
                        state_q <= ST_ADAPT_AWAKE;
                    end else if (dtim_i) begin
                        state_q <= ST_CHECK_TIM;
                    end
                end
                ST_CHECK_TIM: state_q <= tim_aid_set_i ? ST_POLL : ST_DOZE;
                ST_POLL: state_q <= ST_POLL_WAIT;
                ST_POLL_WAIT: begin
                    if (poll_reply_i) begin
                        state_q <= more_data_i ? ST_POLL : ST_DOZE;
                    end
                end
                ST_ADAPT_AWAKE: begin
                    if (mode != MODE_ADAPTIVE) begin
                        state_q <= ST_AWAKE;
                    end else if (idle_exp && !frame_seen) begin
                        state_q <= ST_ANNOUNCE;
                    end
                end
                default: state_q <= ST_AWAKE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            polls_q <= 16'h0000;
        end else if (state_q == ST_POLL) begin
            polls_q <= polls_q + 16'h0001;
        end
    end

    assign send_pm_frame_o = (state_q == ST_ANNOUNCE);
    assign send_ps_poll_o = (state_q == ST_POLL);
    assign client_tx_allowed_o = go_mode && (state_q == ST_GO_WINDOW || !opp_sleep_en_q)
                                 && !absent_o;
    assign radio_awake_o = !(state_q == ST_DOZE || state_q == ST_GO_SLEEP || absent_o);
    assign station_mode_o = mode;

    // ==========================================================
    // Register reads
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_q <= UNMAPPED_READ;
        end else if (avs_read_i && !rd_pend_q) begin
            unique case (avs_address_i)
                REG_CTRL: rdata_q <= ctrl_q;
                REG_STATUS: rdata_q <= {20'h00000, idle_busy, win_busy, noa_run_q,
                                        radio_awake_o, 4'(state_q), noa_left_q[3:0]};
                REG_CTWIN: rdata_q <= {16'h0000, ctwin_ms_q};
                REG_OPP_SLEEP: rdata_q <= {15'h0000, ctwin_live_q, opp_sleep_en_q};
                REG_NOA_CNT: rdata_q <= {24'h000000, noa_cnt_q};
                REG_NOA_START: rdata_q <= noa_start_q;
                REG_NOA_DUR: rdata_q <= noa_dur_q;
                REG_POLLS: rdata_q <= {16'h0000, polls_q};
                default: rdata_q <= UNMAPPED_READ;
            endcase
        end
    end

endmodule : wps_ctrl

// ---- design/wps_ms_timer.sv ----
// Down-counting timer used for windows, absences and the idle period
`timescale 1ns/1ps

module wps_ms_timer (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic load_i,
    input wire logic [31:0] count_i,
    output logic busy_o,
    output logic expire_o
);

    logic [31:0] cnt_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_q <= 32'h0000_0000;
        end else if (load_i) begin
            cnt_q <= count_i;
        end else if (cnt_q != 32'h0000_0000) begin
            cnt_q <= cnt_q - 32'h0000_0001;
        end
    end

    assign busy_o = (cnt_q != 32'h0000_0000);
    // Raw expiry from the registered count; a caller that reloads on expiry can feed it back into load
    assign expire_o = (cnt_q == 32'h0000_0001);

endmodule : wps_ms_timer

// ---- design/wps_pkg.sv ----
// Package for the wireless power-save controller: offsets, fields, timing, states
package wps_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_FREQ_HZ = 200_000_000;
    localparam int IDLE_TIME_MS = 200;
    localparam int IDLE_CYCLES = IDLE_TIME_MS * (CLK_FREQ_HZ / 1000);
    localparam int MS_CYCLES = CLK_FREQ_HZ / 1000;
    localparam int US_CYCLES = CLK_FREQ_HZ / 1_000_000;

    // ==========================================================
    // Register byte offsets
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_STATUS = 6'h04;
    localparam logic [5:0] REG_CTWIN = 6'h08;
    localparam logic [5:0] REG_OPP_SLEEP = 6'h0C;
    localparam logic [5:0] REG_NOA_CNT = 6'h10;
    localparam logic [5:0] REG_NOA_START = 6'h14;
    localparam logic [5:0] REG_NOA_DUR = 6'h18;
    localparam logic [5:0] REG_POLLS = 6'h1C;

    // ==========================================================
    // Fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_GO_BIT = 2;
    localparam int CTRL_NOA_ARM_BIT = 3;
    localparam logic [31:0] RESET_CTRL = 32'h0000_0000;
    localparam logic [15:0] RESET_CTWIN = 16'h000A;
    localparam logic [7:0] RESET_NOA_CNT = 8'h00;
    localparam logic [31:0] RESET_NOA_TIME = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // ==========================================================
    // Station modes written to CTRL
    localparam logic [1:0] MODE_NO_PS = 2'h0;
    localparam logic [1:0] MODE_LEGACY = 2'h1;
    localparam logic [1:0] MODE_ADAPTIVE = 2'h2;

    typedef enum logic [3:0] {
        ST_AWAKE,
        ST_ANNOUNCE,
        ST_WAIT_ACK,
        ST_DOZE,
        ST_CHECK_TIM,
        ST_POLL,
        ST_POLL_WAIT,
        ST_ADAPT_AWAKE,
        ST_GO_WINDOW,
        ST_GO_HOLD,
        ST_GO_SLEEP
    } wps_state_t;

endpackage : wps_pkg

// ---- verif/wps_ap_model.sv ----
// Access point model: acknowledges announce frames, holds buffered frames, answers polls
`timescale 1ns/1ps
module wps_ap_model (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic pm_frame_i,
    input wire logic poll_i,
    input wire logic load_i,
    input wire logic [7:0] frames_i,
    input wire logic [3:0] delay_i,
    output logic ack_o,
    output logic reply_o,
    output logic more_o,
    output logic aid_set_o
);
    logic [7:0] left_q;
    logic [3:0] ack_q, poll_q;
    assign aid_set_o = left_q != 8'h0;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            {ack_o, reply_o, more_o, left_q, ack_q, poll_q} <= '0;
        end else begin
            ack_o <= ack_q == 4'h1;
            reply_o <= poll_q == 4'h1;
            // Outside a reply the flag toggles so a stale value is never trusted
            more_o <= (poll_q == 4'h1) ? (left_q > 8'h1) : ~more_o;
            ack_q <= pm_frame_i ? delay_i : ack_q - 4'(ack_q != 4'h0);
            poll_q <= poll_i ? delay_i : poll_q - 4'(poll_q != 4'h0);
            if (load_i) begin
                left_q <= frames_i;
            end else if (poll_q == 4'h1) begin
                left_q <= left_q - 8'h1;
            end
        end
    end
endmodule : wps_ap_model

// ---- verif/wps_ctrl_assertions.sv ----
// Port-level checker for the power-save controller
`timescale 1ns/1ps
module wps_ctrl_assertions import wps_pkg::*; #(
    parameter int IDLE_COUNT = 100
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic tx_frame_i,
    input wire logic rx_frame_i,
    input wire logic ack_rx_i,
    input wire logic poll_reply_i,
    input wire logic more_data_i,
    input wire logic beacon_i,
    input wire logic probe_resp_i,
    input wire logic send_pm_frame_o,
    input wire logic send_ps_poll_o,
    input wire logic noa_ie_en_o,
    input wire logic client_tx_allowed_o,
    input wire logic radio_awake_o,
    input wire logic [1:0] station_mode_o
);
    // ==========================================================
    // Helper state
    logic pend_q, pout_q, seen_q;
    logic [31:0] idle_q;
    wire logic frame = tx_frame_i | rx_frame_i;
    wire logic adapt = station_mode_o == MODE_ADAPTIVE;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pend_q <= 1'h0;
            pout_q <= 1'h0;
            seen_q <= 1'h0;
            idle_q <= 32'h0;
        end else begin
            pend_q <= send_pm_frame_o | (pend_q & ~ack_rx_i);
            pout_q <= send_ps_poll_o | (pout_q & ~poll_reply_i);
            // Announce on mode entry has no frame before it, so it is not timed
            seen_q <= (frame & adapt) | (seen_q & ~send_pm_frame_o);
            idle_q <= frame ? 32'h0 : idle_q + 32'h1;
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_quiet; station_mode_o == MODE_NO_PS |-> !send_pm_frame_o && !send_ps_poll_o; endproperty
    a_quiet: assert property (p_quiet) else $error("doze request in mode 0");
    property p_pm_mode; send_pm_frame_o |-> station_mode_o != MODE_NO_PS; endproperty
    a_pm_mode: assert property (p_pm_mode) else $error("announce in mode 0");
    property p_wait_ack; pend_q && !ack_rx_i |=> radio_awake_o; endproperty
    a_wait_ack: assert property (p_wait_ack) else $error("doze before ack");
    property p_one_poll; send_ps_poll_o |-> !pout_q; endproperty
    a_one_poll: assert property (p_one_poll) else $error("poll while one outstanding");
    property p_more; poll_reply_i && more_data_i && pout_q |-> ##[1:3] send_ps_poll_o; endproperty
    a_more: assert property (p_more) else $error("no poll for further frame");
    property p_wake; frame && adapt |-> ##[1:3] radio_awake_o; endproperty
    a_wake: assert property (p_wake) else $error("traffic did not wake");
    property p_idle; send_pm_frame_o && adapt && seen_q |-> idle_q >= IDLE_COUNT - 2; endproperty
    a_idle: assert property (p_idle) else $error("power save before idle expiry");
    property p_ctw; client_tx_allowed_o |-> radio_awake_o; endproperty
    a_ctw: assert property (p_ctw) else $error("owner asleep in client window");
    property p_ie; noa_ie_en_o |-> beacon_i || probe_resp_i; endproperty
    a_ie: assert property (p_ie) else $error("absence element off frame");
    c_poll: cover property (poll_reply_i && more_data_i);
    c_adapt: cover property (frame && adapt && !radio_awake_o);
    c_ctw: cover property (client_tx_allowed_o);
endmodule : wps_ctrl_assertions

bind wps_ctrl wps_ctrl_assertions #(.IDLE_COUNT(IDLE_COUNT)) u_wps_ctrl_assertions (
    .clk_i, .sys_rst_i, .tx_frame_i, .rx_frame_i, .ack_rx_i, .poll_reply_i, .more_data_i,
    .beacon_i, .probe_resp_i, .send_pm_frame_o, .send_ps_poll_o, .noa_ie_en_o,
    .client_tx_allowed_o, .radio_awake_o, .station_mode_o);

// ---- verif/wps_ctrl_tb.sv ----
// Self-checking bench for the power-save controller
`timescale 1ns/1ps
module wps_ctrl_tb import wps_pkg::*;;
    localparam int IDLE = 100;
    logic clk_i, sys_rst_i, avs_read_i, avs_write_i, tx_frame_i, rx_frame_i, beacon_i, dtim_i;
    logic all_clients_asleep_i, probe_resp_i, ack_rx_i, poll_reply_i, more_data_i, tim_aid_set_i;
    logic avs_waitrequest_o, send_pm_frame_o, send_ps_poll_o, noa_ie_en_o, client_tx_allowed_o;
    logic radio_awake_o, absent_o, load, abs_q;
    logic [5:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, rd;
    logic [3:0] avs_byteenable_i, dly;
    logic [1:0] station_mode_o;
    logic [7:0] frames;
    int bad_count = 0, comparisons = 0, pm_n = 0, poll_n = 0, abs_n = 0;

    wps_ctrl #(.IDLE_COUNT(IDLE)) u_wps_ctrl (.clk_i, .sys_rst_i, .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
        .tx_frame_i, .rx_frame_i, .ack_rx_i, .beacon_i, .dtim_i, .tim_aid_set_i, .more_data_i,
        .poll_reply_i, .all_clients_asleep_i, .probe_resp_i, .send_pm_frame_o, .send_ps_poll_o,
        .noa_ie_en_o, .client_tx_allowed_o, .radio_awake_o, .absent_o, .station_mode_o);
    wps_ap_model u_wps_ap_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .pm_frame_i(send_pm_frame_o), .poll_i(send_ps_poll_o), .load_i(load), .frames_i(frames),
        .delay_i(dly), .ack_o(ack_rx_i), .reply_o(poll_reply_i), .more_o(more_data_i),
        .aid_set_o(tim_aid_set_i));

    initial begin
        clk_i = 1'h0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (send_pm_frame_o === 1'h1) pm_n++;
        if (send_ps_poll_o === 1'h1) poll_n++;
        if (absent_o === 1'h1 && abs_q !== 1'h1) abs_n++;
        abs_q = absent_o;
    end

    // ==========================================================
    // Tasks
    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic tick(int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    task automatic bus(logic w, logic [5:0] a, logic [31:0] d);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'h0) @(posedge clk_i);
        rd = avs_readdata_o;
        avs_write_i <= 1'h0;
        avs_read_i <= 1'h0;
    endtask : bus
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    // ==========================================================
    // Sequence
    initial begin
        {sys_rst_i, all_clients_asleep_i, avs_byteenable_i, dly} = {2'h3, 4'hF, 4'h8};
        {avs_read_i, avs_write_i, tx_frame_i, rx_frame_i, beacon_i, dtim_i} = '0;
        {probe_resp_i, load, frames, avs_address_i, avs_writedata_i} = '0;
        tick(2);
        sys_rst_i <= 1'h0;
        bus(1'h0, REG_CTWIN, 32'h0);
        chk("ctwin reset", rd, {16'h0, RESET_CTWIN});
        bus(1'h1, 6'h24, 32'hFFFF_FFFF);
        bus(1'h0, 6'h24, 32'h0);
        chk("unmapped", rd, UNMAPPED_READ);
        tick(20);
        #1 chk("mode0 awake", radio_awake_o, 1'h1);
        bus(1'h1, REG_CTRL, {30'h0, MODE_LEGACY});
        tick(3);
        #1 chk("ack wait", radio_awake_o, 1'h1);
        tick(20);
        #1 chk("pm frames", pm_n, 1);
        chk("doze", radio_awake_o, 1'h0);
        chk("station mode", station_mode_o, MODE_LEGACY);
        tick(1);
        // Slow ack above, prompt answers for the polls
        {dly, load, frames} <= {4'h1, 1'h0, 8'h3};
        {beacon_i, dtim_i} <= 2'h3;
        tick(1);
        {beacon_i, dtim_i} <= 2'h0;
        tick(20);
        #1 chk("no aid polls", poll_n, 0);
        tick(1);
        load <= 1'h1;
        tick(1);
        load <= 1'h0;
        {beacon_i, dtim_i} <= 2'h3;
        tick(1);
        {beacon_i, dtim_i} <= 2'h0;
        tick(60);
        #1 chk("polls", poll_n, 3);
        chk("redoze", radio_awake_o, 1'h0);
        bus(1'h0, REG_POLLS, 32'h0);
        chk("poll reg", rd, 32'h3);
        bus(1'h1, REG_CTRL, 32'h0);
        tick(3);
        #1 chk("mode0 wake", radio_awake_o, 1'h1);
        bus(1'h1, REG_CTRL, {30'h0, MODE_ADAPTIVE});
        tick(15);
        #1 chk("adapt doze", radio_awake_o, 1'h0);
        tick(1);
        rx_frame_i <= 1'h1;
        tick(1);
        rx_frame_i <= 1'h0;
        tick(30);
        tx_frame_i <= 1'h1;
        tick(1);
        tx_frame_i <= 1'h0;
        tick(IDLE - 10);
        #1 chk("idle hold", pm_n, 2);
        chk("idle awake", radio_awake_o, 1'h1);
        tick(30);
        #1 chk("idle expiry", pm_n, 3);
        bus(1'h1, REG_CTRL, 32'h0);
        bus(1'h1, REG_CTWIN, 32'h1);
        bus(1'h1, REG_OPP_SLEEP, 32'h1);
        bus(1'h1, REG_CTRL, 32'h1 << CTRL_GO_BIT);
        beacon_i <= 1'h1;
        tick(1);
        beacon_i <= 1'h0;
        tick(3);
        #1 chk("window", client_tx_allowed_o, 1'h1);
        chk("window awake", radio_awake_o, 1'h1);
        bus(1'h1, REG_NOA_CNT, 32'h2);
        bus(1'h1, REG_NOA_START, 32'h1);
        bus(1'h1, REG_NOA_DUR, 32'h1);
        bus(1'h1, REG_CTRL, (32'h1 << CTRL_GO_BIT) | (32'h1 << CTRL_NOA_ARM_BIT));
        beacon_i <= 1'h1;
        @(negedge clk_i) chk("ie beacon", noa_ie_en_o, 1'h1);
        tick(1);
        beacon_i <= 1'h0;
        tick(US_CYCLES / 2);
        probe_resp_i <= 1'h1;
        @(negedge clk_i) chk("ie probe", noa_ie_en_o, 1'h1);
        chk("before start", absent_o, 1'h0);
        tick(1);
        probe_resp_i <= 1'h0;
        tick(US_CYCLES * 3 / 4);
        #1 chk("in absence", absent_o, 1'h1);
        tick(US_CYCLES * 8);
        #1 chk("absences", abs_n, 2);
        complete_run();
    end
    initial begin
        tick(20000);
        bad_count++;
        complete_run();
    end
endmodule : wps_ctrl_tb
